//--- core/pimsk_arbiter.sv
// pimsk_arbiter: combinational pick of the highest ranked eligible source.
// assumes eligible already has masked sources removed; ties go to the lower index.
`timescale 1ns/1ps
`default_nettype none
module pimsk_arbiter
    import pimsk_pkg::*;
(
    input  wire logic [NUM_SRC-1:0]             eligible,
    input  wire logic [NUM_SRC-1:0][CTRL_W-1:0] ctrl,
    output logic                                win_valid,
    output logic [LVL_W-1:0]                    win_lvl,
    output logic [SRC_IDX_W-1:0]                win_src
);
    // scan sources, keeping the largest {level, priority}; level 0 never requests
    always_comb begin
        logic [CTRL_W-1:0] best_key;
        best_key  = '0;
        win_valid = 1'b0;
        win_src   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible[i] && ctrl[i][LVL_LSB +: LVL_W] != LVL_NONE
                && (!win_valid || ctrl[i] > best_key)) begin
                best_key  = ctrl[i];
                win_valid = 1'b1;
                win_src   = SRC_IDX_W'(i);
            end
        end
        win_lvl = best_key[LVL_LSB +: LVL_W];
    end
endmodule
`default_nettype wire

//--- core/pimsk_sticky.sv
// pimsk_sticky: write-one-to-clear event flags; a set in the clear cycle wins.
// assumes set and clear are single-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
module pimsk_sticky
    import pimsk_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [NUM_SRC-1:0] set,
    input  wire logic [NUM_SRC-1:0] clr,
    output logic      [NUM_SRC-1:0] flags
);
    logic [NUM_SRC-1:0] flags_reg;
    logic [NUM_SRC-1:0] flags_next;

    // clear first, then set, so a coincident event is kept
    always_comb begin
        flags_next = (flags_reg & ~clr) | set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule
`default_nettype wire

//--- core/pimsk_top.sv
// pimsk_top: pending capture, mask, priority pick and APB registers.
// assumes request lines come from logic on pclk and the core samples core_lvl/core_src.
// pready is tied high: every transfer is one setup and one access cycle.
// read data is fetched in the setup cycle and stands until the next setup.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pimsk_top
    import pimsk_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NUM_SRC-1:0]   src_req,
    output logic      [LVL_W-1:0]     core_lvl,
    output logic      [SRC_IDX_W-1:0] core_src,
    output logic                      irq
);
    pimsk_state_s       st_reg;
    pimsk_state_s       st_next;
    logic               setup;
    logic               access;
    logic               wr;
    pimsk_reg_e         setup_reg;
    pimsk_reg_e         acc_reg;
    logic [1:0]         ctrl_word;
    logic [NUM_SRC-1:0] eligible;
    logic               win_valid;
    logic [LVL_W-1:0]   win_lvl;
    logic [SRC_IDX_W-1:0] win_src;
    logic [NUM_SRC-1:0] stat_flags;
    logic [NUM_SRC-1:0] stat_clr;

    // map a byte address onto a register, used in setup and access phase
    function automatic pimsk_reg_e decode(input logic [7:0] a);
        if (a[1:0] != 2'h0) begin
            return PIMSK_R_NONE;
        end
        case (a)
            OFF_MASK:                           return PIMSK_R_MASK;
            OFF_PEND:                           return PIMSK_R_PEND;
            OFF_CTRL0, OFF_CTRL0 + 8'h04,
            OFF_CTRL0 + 8'h08:                  return PIMSK_R_CTRL;
            OFF_STAT:                           return PIMSK_R_STAT;
            OFF_IEN:                            return PIMSK_R_IEN;
            default:                            return PIMSK_R_NONE;
        endcase
    endfunction

    // place a source vector at bits 17..8 with zeros elsewhere
    function automatic logic [31:0] place(input logic [NUM_SRC-1:0] v);
        return {{(32-NUM_SRC-MAP_LSB){1'b0}}, v, {MAP_LSB{1'b0}}};
    endfunction

    // apb phase decode
    assign setup     = psel && !penable;
    assign access    = psel && penable;
    assign wr        = access && pwrite;
    assign setup_reg = decode(paddr);
    assign acc_reg   = decode(paddr);
    assign ctrl_word = 2'((paddr - OFF_CTRL0) >> 2);

    // only unmasked pending sources take part in the pick
    assign eligible = st_reg.pend & ~st_reg.mask;

    pimsk_arbiter u_arb (
        .eligible  (eligible),
        .ctrl      (st_reg.ctrl),
        .win_valid (win_valid),
        .win_lvl   (win_lvl),
        .win_src   (win_src)
    );

    // events: a pending bit rising; software writes ones to the status word to clear
    assign stat_clr = (wr && acc_reg == PIMSK_R_STAT) ? pwdata[MAP_LSB +: NUM_SRC] : '0;

    pimsk_sticky u_stat (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (src_req & ~st_reg.pend),
        .clr     (stat_clr),
        .flags   (stat_flags)
    );

    // next state of the whole block
    always_comb begin
        st_next = st_reg;
        // pending copies each request every clock, mask or not
        st_next.pend = src_req;
        // core request registered from the arbiter result
        st_next.lvl  = win_valid ? win_lvl : LVL_NONE;
        st_next.src  = win_valid ? win_src : '0;
        // register writes take effect at the access edge
        if (wr) begin
            case (acc_reg)
                PIMSK_R_MASK: begin
                    // ones mask, zeros enable; reserved bits are not stored
                    st_next.mask = pwdata[MAP_LSB +: NUM_SRC];
                end
                PIMSK_R_CTRL: begin
                    // one byte per source; strobes pick bytes, bytes past the last source drop
                    for (int b = 0; b < 4; b++) begin
                        if (pstrb[b] && (ctrl_word * 4 + b) < NUM_SRC) begin
                            st_next.ctrl[ctrl_word * 4 + b] = pwdata[b*8 +: CTRL_W];
                        end
                    end
                end
                PIMSK_R_IEN: begin
                    // enables only gate event flags onto irq, never the core request
                    st_next.ien = pwdata[MAP_LSB +: NUM_SRC];
                end
                default: begin
                end
            endcase
        end
        // read data and error are prepared in the setup cycle
        if (setup) begin
            st_next.slverr = 1'b0;
            st_next.rdata  = '0;
            // unused bits of every word read as zero
            case (setup_reg)
                PIMSK_R_MASK: st_next.rdata = place(st_reg.mask);
                PIMSK_R_PEND: st_next.rdata = place(st_reg.pend);
                PIMSK_R_STAT: st_next.rdata = place(stat_flags);
                PIMSK_R_IEN:  st_next.rdata = place(st_reg.ien);
                PIMSK_R_CTRL: begin
                    for (int b = 0; b < 4; b++) begin
                        if ((ctrl_word * 4 + b) < NUM_SRC) begin
                            st_next.rdata[b*8 +: CTRL_W] = st_reg.ctrl[ctrl_word * 4 + b];
                        end
                    end
                end
                PIMSK_R_NONE: st_next.slverr = 1'b1;
                default:      st_next.slverr = 1'b1;
            endcase
        end
    end

    // single state register; all sources start masked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.mask   <= MASK_RST;
            st_reg.pend   <= '0;
            st_reg.ctrl   <= {NUM_SRC{CTRL_RST}};
            st_reg.ien    <= IEN_RST;
            st_reg.lvl    <= LVL_NONE;
            st_reg.src    <= '0;
            st_reg.rdata  <= '0;
            st_reg.slverr <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs: zero-wait apb, registered core request, level interrupt
    assign pready   = 1'b1;
    assign prdata   = st_reg.rdata;
    assign pslverr  = access && st_reg.slverr;
    assign core_lvl = st_reg.lvl;
    assign core_src = st_reg.src;
    assign irq      = |(stat_flags & st_reg.ien);

    // helper: does any eligible source beat the arbiter's winner
    logic beaten;
    logic any_req;
    always_comb begin
        beaten  = 1'b0;
        any_req = 1'b0;
        for (int j = 0; j < NUM_SRC; j++) begin
            if (eligible[j] && st_reg.ctrl[j][LVL_LSB +: LVL_W] != LVL_NONE) begin
                any_req = 1'b1;
                if (st_reg.ctrl[j] > st_reg.ctrl[win_src]) begin
                    beaten = 1'b1;
                end
            end
        end
    end

    // all checks below run on pclk; all but mask_reset_a stand down while presetn is low
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // mask bits come out of reset all set, so no source reaches the core
    mask_reset_a: assert property (@(posedge pclk) disable iff (1'b0)
        $rose(presetn) |-> st_reg.mask == MASK_RST)
        else $error("mask not all ones after reset");

    // pending is each request line one clock late
    pend_follow_a: assert property (
        ##1 st_reg.pend == $past(src_req))
        else $error("pending does not follow request");

    // a masked request is still recorded as pending
    masked_pend_a: assert property (
        (src_req[0] && st_reg.mask[0]) |=> st_reg.pend[0])
        else $error("masked request not recorded as pending");

    // a mask write stores the ten defined bits
    mask_write_a: assert property (
        (wr && paddr == OFF_MASK) |=> st_reg.mask == $past(pwdata[MAP_LSB +: NUM_SRC]))
        else $error("mask write not taken");

    // a zero written to a mask bit enables its source
    mask_clear_a: assert property (
        (wr && paddr == OFF_MASK && pwdata[MAP_LSB] == 1'b0) |=> !st_reg.mask[0])
        else $error("zero write did not enable source");

    // mask bits outside the source field read back as zero
    rsvd_zero_a: assert property (
        (access && paddr == OFF_MASK) |-> (prdata[31:18] == '0 && prdata[7:0] == '0))
        else $error("reserved mask bits read nonzero");

    // the mask keeps its value unless software writes it
    mask_hold_a: assert property (
        !(wr && acc_reg == PIMSK_R_MASK) |=> $stable(st_reg.mask))
        else $error("mask changed without a write");

    // an enable write stores the ten defined bits
    ien_write_a: assert property (
        (wr && acc_reg == PIMSK_R_IEN) |=> st_reg.ien == $past(pwdata[MAP_LSB +: NUM_SRC]))
        else $error("enable write not taken");

    // the core only sees a source that was unmasked and pending one clock before
    masked_block_a: assert property (
        (core_lvl != LVL_NONE) |-> core_src == $past(win_src)
            && $past(!st_reg.mask[win_src] && st_reg.pend[win_src]))
        else $error("masked source reached the core");

    // nothing eligible means nothing presented to the core
    idle_core_a: assert property (
        !win_valid |=> core_lvl == LVL_NONE && core_src == 4'h0)
        else $error("core request without an eligible source");

    // no eligible source outranks the pick
    rank_order_a: assert property (
        !beaten && (win_valid == any_req))
        else $error("arbiter winner is not the highest ranked source");

    // the presented level is the winner's level field
    lvl_field_a: assert property (
        win_valid |=> core_lvl == $past(st_reg.ctrl[win_src][LVL_LSB +: LVL_W]))
        else $error("presented level differs from control byte");

    // same level: priority 10 beats priority 01 when only those two compete
    prio_tie_a: assert property (
        (eligible == 10'h003 && st_reg.ctrl[0] == 5'h19 && st_reg.ctrl[1] == 5'h1A)
        |=> core_src == 4'h1)
        else $error("priority 10 not served before 01");

    // unmapped or unaligned access answers with an error
    bad_addr_a: assert property (
        (access && decode(paddr) == PIMSK_R_NONE) |-> pslverr)
        else $error("unmapped access not flagged");

    // an unmapped read returns zero data
    bad_read_a: assert property (
        (access && !pwrite && acc_reg == PIMSK_R_NONE) |-> prdata == 32'h00000000)
        else $error("unmapped read returned data");

    // a refused write leaves mask, enables and control bytes alone
    bad_write_a: assert property (
        (wr && acc_reg == PIMSK_R_NONE)
        |=> $stable(st_reg.mask) && $stable(st_reg.ien) && $stable(st_reg.ctrl))
        else $error("refused write changed a register");

    // read data only moves at the end of a setup cycle
    rdata_hold_a: assert property (
        !setup |=> $stable(prdata))
        else $error("read data moved outside setup");

    // pending bits outside the source field read as zero
    pend_rsvd_a: assert property (
        (access && acc_reg == PIMSK_R_PEND)
        |-> (prdata & 32'hFFFC00FF) == 32'h00000000)
        else $error("pending spare bits read nonzero");

    // status bits outside the source field read as zero
    stat_rsvd_a: assert property (
        (access && acc_reg == PIMSK_R_STAT)
        |-> (prdata & 32'hFFFC00FF) == 32'h00000000)
        else $error("status spare bits read nonzero");

    // control bytes read back with their spare top bits clear
    ctrl_rsvd_a: assert property (
        (access && acc_reg == PIMSK_R_CTRL)
        |-> (prdata & 32'hE0E0E0E0) == 32'h00000000)
        else $error("control byte spare bits read nonzero");

    // a control write with a byte strobe low keeps that byte
    ctrl_strobe_a: assert property (
        (wr && acc_reg == PIMSK_R_CTRL && ctrl_word == 2'h0 && !pstrb[1])
        |=> $stable(st_reg.ctrl[1]))
        else $error("control byte written with its strobe low");

    // a new event on an enabled source raises irq
    irq_event_a: assert property (
        (src_req[0] && !st_reg.pend[0] && st_reg.ien[0] && !wr)
        |=> irq)
        else $error("enabled event did not raise irq");

    // per-source checks: masking, event set over clear, clear by a written one
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        src_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
            st_reg.mask[g] |=> !(core_lvl != LVL_NONE && core_src == SRC_IDX_W'(g)))
            else $error("masked source presented to the core");
        mask_set_a: assert property (@(posedge pclk) disable iff (!presetn)
            (wr && acc_reg == PIMSK_R_MASK && pwdata[MAP_LSB + g]) |=> st_reg.mask[g])
            else $error("written one did not mask the source");
        mask_en_a: assert property (@(posedge pclk) disable iff (!presetn)
            (wr && acc_reg == PIMSK_R_MASK && !pwdata[MAP_LSB + g]) |=> !st_reg.mask[g])
            else $error("written zero did not enable the source");
        set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
            (src_req[g] && !st_reg.pend[g]) |=> stat_flags[g])
            else $error("event flag lost against a clear");
        flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
            (wr && acc_reg == PIMSK_R_STAT && pwdata[MAP_LSB + g]
            && !(src_req[g] && !st_reg.pend[g])) |=> !stat_flags[g])
            else $error("event flag not cleared by a written one");
    end

    // main scenarios seen at least once
    masked_pend_c: cover property (st_reg.mask[0] && st_reg.pend[0]);
    top_level_c:   cover property (core_lvl == 3'h7);
    irq_fire_c:    cover property ($rose(irq));
    bad_addr_c:    cover property (pslverr);
    prio_tie_c:    cover property (eligible == 10'h003);
endmodule
`default_nettype wire

//--- pkg/pimsk_pkg.sv
// pimsk_pkg: constants and types of the primary interrupt priority and mask stage.
// assumes a 32-bit APB slave port and ten internal request sources on pclk.
// How it works
// - rank requests by 3-bit level, 7 highest, then 2-bit in-level priority, 11 highest.
// - same level, priority code 10 is served before priority code 01.
// - the mask suppresses every source, whatever drives its request line.
// - mask bits sit at 17..8, one per source; other bits reserved.
// - writing one to a mask bit masks that source.
// - writing zero to a mask bit enables that source.
// - a masked source still sets its pending bit.
// - a masked source never reaches the processor core; a source masked while it wins stays on core_lvl/core_src one more clock.
// - reset sets every defined mask bit, so all sources start masked.
// - control byte bits 4..2 hold the level the request is presented at.
// - control byte bits 1..0 hold in-level priority, 00 lowest, 11 highest.
// - pending bits sample the request lines every clock, even when masked.
package pimsk_pkg;
    localparam int          NUM_SRC      = 10;
    localparam int          SRC_IDX_W    = 4;
    localparam int          MAP_LSB      = 8;          // mask and pending field start
    localparam int          LVL_LSB      = 2;
    localparam int          LVL_W        = 3;
    localparam int          PRIO_LSB     = 0;
    localparam int          PRIO_W       = 2;
    localparam int          CTRL_W       = 5;          // stored control byte bits 4..0
    localparam int          CTRL_WORDS   = 3;          // four control bytes per word
    // register byte offsets
    localparam logic [7:0]  OFF_MASK     = 8'h00;
    localparam logic [7:0]  OFF_PEND     = 8'h04;
    localparam logic [7:0]  OFF_CTRL0    = 8'h08;      // ctrl words at 08, 0C, 10
    localparam logic [7:0]  OFF_STAT     = 8'h14;
    localparam logic [7:0]  OFF_IEN      = 8'h18;
    // reset values
    localparam logic [NUM_SRC-1:0] MASK_RST = 10'h3FF;
    localparam logic [CTRL_W-1:0]  CTRL_RST = 5'h00;
    localparam logic [NUM_SRC-1:0] IEN_RST  = 10'h000;
    localparam logic [LVL_W-1:0]   LVL_NONE = 3'h0;    // level 0: nothing presented

    typedef enum {
        PIMSK_R_MASK, PIMSK_R_PEND, PIMSK_R_CTRL, PIMSK_R_STAT, PIMSK_R_IEN, PIMSK_R_NONE
    } pimsk_reg_e;

    typedef struct packed {
        logic [NUM_SRC-1:0]             mask;
        logic [NUM_SRC-1:0]             pend;
        logic [NUM_SRC-1:0][CTRL_W-1:0] ctrl;
        logic [NUM_SRC-1:0]             ien;
        logic [LVL_W-1:0]               lvl;
        logic [SRC_IDX_W-1:0]           src;
        logic [31:0]                    rdata;
        logic                           slverr;
    } pimsk_state_s;
endpackage

//--- tb/pimsk_core_model.sv
// pimsk_core_model: processor core interrupt input facing the block.
// assumes core_lvl/core_src are registers on pclk; ipl is the core's own mask level.
`timescale 1ns/1ps
`default_nettype none
module pimsk_core_model
    import pimsk_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [LVL_W-1:0]     core_lvl,
    input  wire logic [SRC_IDX_W-1:0] core_src,
    input  wire logic [LVL_W-1:0]     ipl,
    output logic                      take,
    output logic      [SRC_IDX_W-1:0] take_src
);
    // core accepts only above its mask level, which software raises before masking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take     <= 1'b0;
            take_src <= 4'h0;
        end else begin
            take     <= (core_lvl > ipl);
            take_src <= core_src;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// tb_top: self-checking bench for pimsk_top over APB with a core model.
// assumes zero-wait APB slave and the register offsets of pimsk_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pimsk_pkg::*;
;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, take;
    logic [7:0]           paddr;
    logic [3:0]           pstrb;
    logic [31:0]          pwdata, prdata, cw_d, cw_e;
    logic [NUM_SRC-1:0]   src_req;
    logic [LVL_W-1:0]     core_lvl, ipl;
    logic [SRC_IDX_W-1:0] core_src, take_src;
    logic [33:0]          note_q[$];
    logic [33:0]          note;
    int                   error_cnt, tests_run;
    int unsigned          seed;
    // unique level and priority per source, level never 0
    logic [4:0] ctrl_tab [NUM_SRC] = '{5'h19, 5'h1A, 5'h1C, 5'h07, 5'h0D,
                                       5'h10, 5'h1F, 5'h04, 5'h16, 5'h0B};
    logic [NUM_SRC-1:0] dir_m [4] = '{10'h000, 10'h000, 10'h002, 10'h3FF};
    logic [NUM_SRC-1:0] dir_r [4] = '{10'h003, 10'h007, 10'h003, 10'h3FF};

    pimsk_top pimsk_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_req(src_req), .core_lvl(core_lvl),
        .core_src(core_src), .irq(irq));
    pimsk_core_model pimsk_core_model_inst (.pclk(pclk), .presetn(presetn),
        .core_lvl(core_lvl), .core_src(core_src), .ipl(ipl), .take(take), .take_src(take_src));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // apb transfer; the expected answer is noted before the request goes out
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        int n;
        n = 0;
        note_q.push_back({wr, ee, ed});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            summarize();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // highest key among eligible sources, lower index on a tie
    function automatic logic [6:0] pick(input logic [NUM_SRC-1:0] el);
        logic [4:0] best;
        logic [3:0] s;
        best = 5'h00;
        s = 4'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (el[i] && ctrl_tab[i] > best) begin
                best = ctrl_tab[i];
                s = 4'(i);
            end
        end
        return {best[4:2], s};
    endfunction

    // one mask and request setting, then core view and pending read
    task automatic vec(input logic [NUM_SRC-1:0] m, input logic [NUM_SRC-1:0] r);
        logic [6:0] e;
        e = pick(r & ~m);
        @(posedge pclk);
        ipl <= LVL_W'($urandom_range(7, 0));
        apb(1'b1, OFF_MASK, {14'h3FFF, m, 8'hFF}, 32'h0, 1'b0);
        apb(1'b0, OFF_MASK, 32'h0, {14'h0, m, 8'h00}, 1'b0);
        src_req <= r;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("core_lvl", 32'(core_lvl), 32'(e[6:4]));
        chk("core_src", 32'(core_src), 32'(e[3:0]));
        chk("take", 32'(take), 32'(e[6:4] > ipl));
        chk("take_src", 32'(take_src), 32'(e[3:0]));
        apb(1'b0, OFF_PEND, 32'h0, {14'h0, r, 8'h00}, 1'b0);
    endtask

    // watcher: every completed transfer is compared with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = note_q.pop_front();
            chk("pslverr", 32'(pslverr), 32'(note[32]));
            if (!note[33]) chk("prdata", prdata, note[31:0]);
        end
    end

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pstrb = 4'hF;
        pwdata = 32'h0;
        src_req = 10'h000;
        ipl = 3'h0;
        seed = $urandom(25182);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_MASK, 32'h0, 32'h0003FF00, 1'b0);
        for (int w = 0; w < CTRL_WORDS; w++) begin
            for (int b = 0; b < 4; b++) begin
                cw_e[8*b +: 8] = (4*w + b < NUM_SRC) ? {3'h0, ctrl_tab[4*w + b]} : 8'h00;
                cw_d[8*b +: 8] = cw_e[8*b +: 8] | 8'hE0;
            end
            pstrb <= 4'h5;
            apb(1'b1, OFF_CTRL0 + 8'(4*w), cw_d, 32'h0, 1'b0);
            pstrb <= 4'hF;
            apb(1'b0, OFF_CTRL0 + 8'(4*w), 32'h0, cw_e & 32'h00FF00FF, 1'b0);
            apb(1'b1, OFF_CTRL0 + 8'(4*w), cw_d, 32'h0, 1'b0);
            apb(1'b0, OFF_CTRL0 + 8'(4*w), 32'h0, cw_e, 1'b0);
        end
        src_req <= 10'h3FF;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("core_lvl", 32'(core_lvl), 32'h0);
        apb(1'b0, OFF_PEND, 32'h0, 32'h0003FF00, 1'b0);
        for (int k = 0; k < 24; k++) begin
            if (k < 4) vec(dir_m[k], dir_r[k]);
            else vec(NUM_SRC'($urandom), NUM_SRC'($urandom));
        end
        // event flag raised, gated by its enable, cleared by writing one
        src_req <= 10'h000;
        apb(1'b1, OFF_STAT, 32'hFFFFFFFF, 32'h0, 1'b0);
        apb(1'b1, OFF_IEN, 32'h00000100, 32'h0, 1'b0);
        src_req <= 10'h001;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b0, OFF_STAT, 32'h0, 32'h00000100, 1'b0);
        apb(1'b1, OFF_IEN, 32'h0, 32'h0, 1'b0);
        @(negedge pclk);
        chk("irq", 32'(irq), 32'h0);
        apb(1'b1, OFF_IEN, 32'h00000100, 32'h0, 1'b0);
        @(negedge pclk);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, OFF_STAT, 32'h00000100, 32'h0, 1'b0);
        @(negedge pclk);
        chk("irq", 32'(irq), 32'h0);
        // unmapped and unaligned places are refused
        apb(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h1C, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
        repeat (2) @(posedge pclk);
        summarize();
    end
endmodule
`default_nettype wire
